/* adl_pkg.sv */
// constants and types for the add-immediate and register-add datapath
//
// Contract
// [RULE1] add-immediate: accumulator plus byte into accumulator
// [RULE2] register-add: accumulator plus indexed data register
// [RULE3] destination bit 0: sum to accumulator only
// [RULE4] destination bit 1: sum back to register
// [RULE5] bank-mode 0 access bank, 1 bank pointer
// [RULE6] extended set: index up to 95 is indexed
// [RULE7] both adds update five arithmetic status flags
// [RULE8] one word, one cycle: decode, read, compute, write
// [RULE9] carry, nibble carry, sign, zero, signed wrap
package adl_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int BUS_AW = 5;
  localparam int BUS_DW = 32;
  localparam int BUS_BE = 4;

  localparam logic [BUS_AW-1:0] OFF_CTRL     = 5'h00;
  localparam logic [BUS_AW-1:0] OFF_INSN     = 5'h04;
  localparam logic [BUS_AW-1:0] OFF_ACC      = 5'h08;
  localparam logic [BUS_AW-1:0] OFF_BANK     = 5'h0C;
  localparam logic [BUS_AW-1:0] OFF_STATUS   = 5'h10;
  localparam logic [BUS_AW-1:0] OFF_IDX_BASE = 5'h14;
  localparam logic [BUS_AW-1:0] OFF_MEM_ADDR = 5'h18;
  localparam logic [BUS_AW-1:0] OFF_MEM_DATA = 5'h1C;

  localparam int CTRL_EXT_BIT = 0;
  localparam int LANE_LOW     = 0;

  // ----------------------------------------------------------------
  // data memory and addressing
  // ----------------------------------------------------------------
  localparam int MEM_AW    = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int BYTE_W    = 8;
  localparam int BANK_W    = 4;
  localparam int INSN_W    = 16;

  localparam logic [BYTE_W-1:0] ACCESS_SPLIT   = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [BYTE_W-1:0] IDX_LIMIT      = 8'h5F;

  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_ADD_IMM = 8'h0F;
  localparam logic [5:0] OPC_ADD_REG = 6'h09;
  localparam int DEST_BIT  = 9;
  localparam int BMODE_BIT = 8;

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  localparam int FLAGS_W  = 5;
  localparam int FLAG_C   = 0;
  localparam int FLAG_DC  = 1;
  localparam int FLAG_Z   = 2;
  localparam int FLAG_OV  = 3;
  localparam int FLAG_N   = 4;
  localparam int NIB_W    = 4;

  // ----------------------------------------------------------------
  // sequencer states, gray along the instruction path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_Q1    = 3'h1,
    ST_Q2    = 3'h3,
    ST_Q3    = 3'h2,
    ST_Q4    = 3'h6,
    ST_MRD   = 3'h4,
    ST_MWAIT = 3'h5
  } adl_state_t;

endpackage

/* adl_mem_if.sv */
// link between the datapath and its data memory
`timescale 1ns/10ps
interface adl_mem_if;
  logic [adl_pkg::MEM_AW-1:0] addr;
  logic                       we;
  logic [adl_pkg::BYTE_W-1:0] wdata;
  logic [adl_pkg::BYTE_W-1:0] rdata;

  modport owner (output addr, output we, output wdata, input rdata);
  modport store (input addr, input we, input wdata, output rdata);
endinterface

/* adl_dmem.sv */
// data memory with registered read data
`timescale 1ns/10ps
module adl_dmem (
  input wire logic   clk,
  adl_mem_if.store   port
);

  logic [adl_pkg::BYTE_W-1:0] mem [adl_pkg::MEM_DEPTH];

  // ----------------------------------------------------------------
  // write and registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    port.rdata <= mem[port.addr];
  end

endmodule

/* adl_core.sv */
// add-immediate and register-add datapath with avalon register slave
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module adl_core (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RST,
  input  wire logic [adl_pkg::BUS_AW-1:0]  AVS_ADDRESS,
  input  wire logic                        AVS_READ,
  input  wire logic                        AVS_WRITE,
  input  wire logic [adl_pkg::BUS_DW-1:0]  AVS_WRITEDATA,
  input  wire logic [adl_pkg::BUS_BE-1:0]  AVS_BYTEENABLE,
  output logic      [adl_pkg::BUS_DW-1:0]  AVS_READDATA,
  output logic                             AVS_WAITREQUEST
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  adl_pkg::adl_state_t                state;
  logic [adl_pkg::INSN_W-1:0]         insn;
  logic [adl_pkg::BYTE_W-1:0]         acc;
  logic [adl_pkg::BANK_W-1:0]         bank_pointer;
  logic [adl_pkg::FLAGS_W-1:0]        flags;
  logic                               ext_enable;
  logic [adl_pkg::MEM_AW-1:0]         idx_base;
  logic [adl_pkg::MEM_AW-1:0]         mem_index;
  logic [adl_pkg::MEM_AW-1:0]         eff_addr;
  logic [adl_pkg::BYTE_W-1:0]         sum_res;
  logic [adl_pkg::FLAGS_W-1:0]        sum_flags;

  adl_mem_if mem_bus ();

  adl_dmem u_dmem (
    .clk  (CORE_CLK),
    .port (mem_bus.store)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic                        is_imm;
  logic                        is_reg;
  logic                        dest_reg;
  logic                        bank_mode;
  logic [adl_pkg::BYTE_W-1:0]  reg_index;

  assign is_imm    = (insn[adl_pkg::INSN_W-1 -: $bits(adl_pkg::OPC_ADD_IMM)]
                      == adl_pkg::OPC_ADD_IMM);
  assign is_reg    = (insn[adl_pkg::INSN_W-1 -: $bits(adl_pkg::OPC_ADD_REG)]
                      == adl_pkg::OPC_ADD_REG);
  assign dest_reg  = insn[adl_pkg::DEST_BIT];
  assign bank_mode = insn[adl_pkg::BMODE_BIT];
  assign reg_index = insn[adl_pkg::BYTE_W-1:0];

  // ----------------------------------------------------------------
  // bus handshake terms
  // ----------------------------------------------------------------
  logic bus_req;
  logic lane0;
  logic start;
  logic start_exec;
  logic start_mrd;
  logic start_simple;
  logic done;
  logic sw_write;
  logic exec_commit;

  assign bus_req      = AVS_READ | AVS_WRITE;
  assign lane0        = AVS_BYTEENABLE[adl_pkg::LANE_LOW];
  assign start        = bus_req && AVS_WAITREQUEST &&
                        (state == adl_pkg::ST_IDLE);
  assign start_exec   = start && AVS_WRITE && lane0 &&
                        (AVS_ADDRESS == adl_pkg::OFF_INSN);
  assign start_mrd    = start && AVS_READ &&
                        (AVS_ADDRESS == adl_pkg::OFF_MEM_DATA);
  assign start_simple = start && !start_exec && !start_mrd;
  assign done         = bus_req && !AVS_WAITREQUEST;
  assign sw_write     = AVS_WRITE && !AVS_WAITREQUEST && lane0 &&
                        (state == adl_pkg::ST_IDLE);
  assign exec_commit  = done && (state == adl_pkg::ST_Q4);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // [RULE8] four phase cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state <= adl_pkg::ST_IDLE;
    end else begin
      case (state)
        adl_pkg::ST_IDLE: begin
          if (start_exec) begin
            state <= adl_pkg::ST_Q1;
          end else if (start_mrd) begin
            state <= adl_pkg::ST_MRD;
          end
        end
        adl_pkg::ST_Q1:    state <= adl_pkg::ST_Q2;
        adl_pkg::ST_Q2:    state <= adl_pkg::ST_Q3;
        adl_pkg::ST_Q3:    state <= adl_pkg::ST_Q4;
        adl_pkg::ST_Q4: begin
          if (done) begin
            state <= adl_pkg::ST_IDLE;
          end
        end
        adl_pkg::ST_MRD:   state <= adl_pkg::ST_MWAIT;
        adl_pkg::ST_MWAIT: state <= adl_pkg::ST_IDLE;
        default:           state <= adl_pkg::ST_IDLE;
      endcase
    end
  end

  // [RULE8] single word latch
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      insn <= '0;
    end else if (start_exec) begin
      insn <= AVS_WRITEDATA[adl_pkg::INSN_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // address resolution in the decode phase
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      eff_addr <= '0;
    end else if (state == adl_pkg::ST_Q1) begin
      // [RULE5] bank pointer selection
      if (bank_mode) begin
        eff_addr <= {bank_pointer, reg_index};
      // [RULE6] indexed literal offset
      end else if (ext_enable && (reg_index <= adl_pkg::IDX_LIMIT)) begin
        eff_addr <= adl_pkg::MEM_AW'(idx_base + adl_pkg::MEM_AW'(reg_index));
      // [RULE5] access bank split
      end else if (reg_index < adl_pkg::ACCESS_SPLIT) begin
        eff_addr <= {adl_pkg::ACCESS_LO_BANK, reg_index};
      end else begin
        eff_addr <= {adl_pkg::ACCESS_HI_BANK, reg_index};
      end
    end
  end

  // ----------------------------------------------------------------
  // adder and flags
  // ----------------------------------------------------------------
  logic [adl_pkg::BYTE_W-1:0]  operand;
  logic [adl_pkg::BYTE_W:0]    sum_wide;
  logic [adl_pkg::NIB_W:0]     nib_wide;
  logic [adl_pkg::FLAGS_W-1:0] next_flags;

  // [RULE1] immediate or [RULE2] register operand
  assign operand  = is_imm ? reg_index : mem_bus.rdata;
  assign sum_wide = {1'b0, acc} + {1'b0, operand};
  assign nib_wide = {1'b0, acc[adl_pkg::NIB_W-1:0]} +
                    {1'b0, operand[adl_pkg::NIB_W-1:0]};

  // [RULE9] flag equations
  always_comb begin
    next_flags                  = '0;
    next_flags[adl_pkg::FLAG_C]  = sum_wide[adl_pkg::BYTE_W];
    next_flags[adl_pkg::FLAG_DC] = nib_wide[adl_pkg::NIB_W];
    next_flags[adl_pkg::FLAG_Z]  =
      (sum_wide[adl_pkg::BYTE_W-1:0] == '0);
    next_flags[adl_pkg::FLAG_N]  = sum_wide[adl_pkg::BYTE_W-1];
    next_flags[adl_pkg::FLAG_OV] =
      (acc[adl_pkg::BYTE_W-1] == operand[adl_pkg::BYTE_W-1]) &&
      (sum_wide[adl_pkg::BYTE_W-1] != acc[adl_pkg::BYTE_W-1]);
  end

  // [RULE8] process phase
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sum_res   <= '0;
      sum_flags <= '0;
    end else if (state == adl_pkg::ST_Q3) begin
      sum_res   <= sum_wide[adl_pkg::BYTE_W-1:0];
      sum_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // destination write and software registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      acc <= '0;
    // [RULE1] [RULE3] accumulator destination
    end else if (exec_commit && (is_imm || (is_reg && !dest_reg))) begin
      acc <= sum_res;
    end else if (sw_write && (AVS_ADDRESS == adl_pkg::OFF_ACC)) begin
      acc <= AVS_WRITEDATA[adl_pkg::BYTE_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      flags <= '0;
    // [RULE7] flag update
    end else if (exec_commit && (is_imm || is_reg)) begin
      flags <= sum_flags;
    end else if (sw_write && (AVS_ADDRESS == adl_pkg::OFF_STATUS)) begin
      flags <= AVS_WRITEDATA[adl_pkg::FLAGS_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bank_pointer <= '0;
      ext_enable   <= 1'b0;
      idx_base     <= '0;
      mem_index    <= '0;
    end else if (sw_write) begin
      case (AVS_ADDRESS)
        adl_pkg::OFF_BANK:
          bank_pointer <= AVS_WRITEDATA[adl_pkg::BANK_W-1:0];
        adl_pkg::OFF_CTRL:
          ext_enable <= AVS_WRITEDATA[adl_pkg::CTRL_EXT_BIT];
        adl_pkg::OFF_IDX_BASE:
          idx_base <= AVS_WRITEDATA[adl_pkg::MEM_AW-1:0];
        adl_pkg::OFF_MEM_ADDR:
          mem_index <= AVS_WRITEDATA[adl_pkg::MEM_AW-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory port
  // ----------------------------------------------------------------
  logic exec_phase;

  assign exec_phase = (state == adl_pkg::ST_Q1) ||
                      (state == adl_pkg::ST_Q2) ||
                      (state == adl_pkg::ST_Q3) ||
                      (state == adl_pkg::ST_Q4);

  assign mem_bus.addr  = exec_phase ? eff_addr : mem_index;
  // [RULE4] register destination
  assign mem_bus.we    = (exec_commit && is_reg && dest_reg) ||
                         (sw_write &&
                          (AVS_ADDRESS == adl_pkg::OFF_MEM_DATA));
  assign mem_bus.wdata = exec_phase ? sum_res :
                         AVS_WRITEDATA[adl_pkg::BYTE_W-1:0];

  // ----------------------------------------------------------------
  // read data and waitrequest
  // ----------------------------------------------------------------
  logic [adl_pkg::BUS_DW-1:0] next_readdata;

  always_comb begin
    next_readdata = '0;
    case (AVS_ADDRESS)
      adl_pkg::OFF_CTRL:     next_readdata = adl_pkg::BUS_DW'(ext_enable);
      adl_pkg::OFF_INSN:     next_readdata = adl_pkg::BUS_DW'(insn);
      adl_pkg::OFF_ACC:      next_readdata = adl_pkg::BUS_DW'(acc);
      adl_pkg::OFF_BANK:     next_readdata = adl_pkg::BUS_DW'(bank_pointer);
      adl_pkg::OFF_STATUS:   next_readdata = adl_pkg::BUS_DW'(flags);
      adl_pkg::OFF_IDX_BASE: next_readdata = adl_pkg::BUS_DW'(idx_base);
      adl_pkg::OFF_MEM_ADDR: next_readdata = adl_pkg::BUS_DW'(mem_index);
      default:               next_readdata = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      AVS_READDATA <= '0;
    end else if (start_simple && AVS_READ) begin
      AVS_READDATA <= next_readdata;
    end else if (state == adl_pkg::ST_MWAIT) begin
      AVS_READDATA <= adl_pkg::BUS_DW'(mem_bus.rdata);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (!AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (start_simple ||
                 (state == adl_pkg::ST_Q3) ||
                 (state == adl_pkg::ST_MWAIT)) begin
      AVS_WAITREQUEST <= 1'b0;
    end
  end

endmodule

/* adl_core_asserts.sv */
// bus timing and read-data checks on the add datapath ports
`timescale 1ns/10ps
module adl_core_asserts (
  input wire logic                       CORE_CLK,
  input wire logic                       RST,
  input wire logic [adl_pkg::BUS_AW-1:0] AVS_ADDRESS,
  input wire logic                       AVS_READ,
  input wire logic                       AVS_WRITE,
  input wire logic [adl_pkg::BUS_BE-1:0] AVS_BYTEENABLE,
  input wire logic [adl_pkg::BUS_DW-1:0] AVS_READDATA,
  input wire logic                       AVS_WAITREQUEST
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // request tracking
  // ----------------------------------------------------------------
  logic busy;
  logic start;
  logic exec;
  logic mrd;
  assign start = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & ~busy;
  assign exec  = AVS_WRITE & (AVS_ADDRESS == adl_pkg::OFF_INSN);
  assign mrd   = AVS_READ & (AVS_ADDRESS == adl_pkg::OFF_MEM_DATA);
  always_ff @(posedge CORE_CLK) begin
    if (RST) busy <= 1'b0;
    else if (!AVS_WAITREQUEST) busy <= 1'b0;
    else if (start) busy <= 1'b1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_wait_idle: assert property (!busy && !start |-> AVS_WAITREQUEST)
    else $error("answer without a request");
  a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  a_simple_lat: assert property (start && !exec && !mrd |=> !AVS_WAITREQUEST)
    else $error("simple access not answered in one cycle");
  a_memrd_lat: assert property (start && mrd
    |=> AVS_WAITREQUEST [*2] ##1 !AVS_WAITREQUEST)
    else $error("memory read answer at wrong cycle");
  a_exec_lat: assert property (
    start && exec && AVS_BYTEENABLE[0]
    |=> AVS_WAITREQUEST [*3] ##1 !AVS_WAITREQUEST)
    else $error("instruction not done in four cycles");
  a_unmapped_zero: assert property (!AVS_WAITREQUEST && AVS_READ
    && AVS_ADDRESS[1:0] != 2'h0 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (!AVS_WAITREQUEST && AVS_READ
    |-> AVS_READDATA[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_ctrl_width: assert property (!AVS_WAITREQUEST && AVS_READ
    && AVS_ADDRESS == adl_pkg::OFF_CTRL |-> AVS_READDATA[31:1] == 31'h0)
    else $error("control read wider than one bit");
  a_data_hold: assert property (!(AVS_READ && !AVS_WAITREQUEST)
    |-> $stable(AVS_READDATA))
    else $error("read data moved without a read answer");
endmodule

bind adl_core adl_core_asserts u_asserts (
  .CORE_CLK       (CORE_CLK),
  .RST            (RST),
  .AVS_ADDRESS    (AVS_ADDRESS),
  .AVS_READ       (AVS_READ),
  .AVS_WRITE      (AVS_WRITE),
  .AVS_BYTEENABLE (AVS_BYTEENABLE),
  .AVS_READDATA   (AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST)
);

/* adl_host.sv */
// avalon master model that issues register accesses
`timescale 1ns/10ps
module adl_host (
  input  wire logic                       clk,
  input  wire logic                       wait_req,
  input  wire logic [adl_pkg::BUS_DW-1:0] rdata,
  output logic      [adl_pkg::BUS_AW-1:0] addr,
  output logic                            rd,
  output logic                            wr,
  output logic      [adl_pkg::BUS_DW-1:0] wdata,
  output logic      [adl_pkg::BUS_BE-1:0] be
);
  initial begin
    addr  = 5'h00;
    rd    = 1'b0;
    wr    = 1'b0;
    wdata = 32'h0;
    be    = 4'h0;
  end
  // holds the request until waitrequest is seen low at an edge
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] e,
                      output logic [31:0] q);
    @(posedge clk);
    rd    <= ~w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    be    <= e;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    rd    <= 1'b0;
    wr    <= 1'b0;
    wdata <= ~d;
  endtask
endmodule

/* adl_core_tb_top.sv */
// self-checking bench for the add datapath
`timescale 1ns/10ps
module adl_core_tb_top;
  logic        core_clk;
  logic        rst;
  logic        wait_req;
  logic [31:0] rdata;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] q;
  int          fails;
  int          n_compared;
  int          cycles;
  logic [7:0]  ta [5] = '{8'h10, 8'hFF, 8'h7F, 8'h80, 8'h08};
  logic [7:0]  tk [5] = '{8'h15, 8'h01, 8'h01, 8'h80, 8'h08};

  adl_core dut (.CORE_CLK(core_clk), .RST(rst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req));
  adl_host host (.clk(core_clk), .wait_req(wait_req), .rdata(rdata),
    .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .be(be));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // access tasks and reference
  // ----------------------------------------------------------------
  task automatic wr32(logic [4:0] a, logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, 4'hF, r);
  endtask
  task automatic chk(logic [4:0] a, logic [31:0] exp);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0, 4'hF, r);
    n_compared++;
    if (r !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, r, exp);
    end
  endtask
  function automatic logic [31:0] flags(logic [7:0] a, logic [7:0] b);
    logic [8:0]  s;
    logic [4:0]  h;
    logic [31:0] f;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    f = 32'h0;
    f[adl_pkg::FLAG_C]  = s[8];
    f[adl_pkg::FLAG_DC] = h[4];
    f[adl_pkg::FLAG_Z]  = (s[7:0] == 8'h00);
    f[adl_pkg::FLAG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
    f[adl_pkg::FLAG_N]  = s[7];
    return f;
  endfunction
  task automatic add_imm(logic [7:0] a, logic [7:0] k);
    wr32(adl_pkg::OFF_ACC, {24'h0, a});
    wr32(adl_pkg::OFF_STATUS, ~flags(a, k) & 32'h1F);
    wr32(adl_pkg::OFF_INSN, {16'h0, adl_pkg::OPC_ADD_IMM, k});
    chk(adl_pkg::OFF_ACC, {24'h0, a + k});
    chk(adl_pkg::OFF_STATUS, flags(a, k));
  endtask
  task automatic add_reg(logic [15:0] op, logic [11:0] l,
                         logic [7:0] a, logic [7:0] m);
    logic d;
    d = op[adl_pkg::DEST_BIT];
    wr32(adl_pkg::OFF_MEM_ADDR, {20'h0, l});
    wr32(adl_pkg::OFF_MEM_DATA, {24'h0, m});
    wr32(adl_pkg::OFF_ACC, {24'h0, a});
    wr32(adl_pkg::OFF_STATUS, ~flags(a, m) & 32'h1F);
    wr32(adl_pkg::OFF_INSN, {16'h0, op});
    chk(adl_pkg::OFF_MEM_DATA, {24'h0, d ? a + m : m});
    chk(adl_pkg::OFF_ACC, {24'h0, d ? a : a + m});
    chk(adl_pkg::OFF_STATUS, flags(a, m));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    chk(adl_pkg::OFF_ACC, 32'h0);
    chk(adl_pkg::OFF_STATUS, 32'h0);
    chk(adl_pkg::OFF_CTRL, 32'h0);
    chk(5'h02, 32'h0);
    host.xfer(1'b1, adl_pkg::OFF_ACC, 32'h55, 4'hE, q);
    chk(adl_pkg::OFF_ACC, 32'h0);
    for (int i = 0; i < 5; i++) add_imm(ta[i], tk[i]);
    wr32(adl_pkg::OFF_INSN, 32'hFFFF);
    chk(adl_pkg::OFF_ACC, 32'h10);
    chk(adl_pkg::OFF_STATUS, 32'h02);
    chk(adl_pkg::OFF_INSN, 32'hFFFF);
    add_reg(16'h2420, 12'h020, 8'h17, 8'hC2);
    add_reg(16'h2620, 12'h020, 8'h17, 8'h05);
    add_reg(16'h2485, 12'hF85, 8'h01, 8'h7F);
    wr32(adl_pkg::OFF_BANK, 32'h3);
    add_reg(16'h2785, 12'h385, 8'hFF, 8'h01);
    wr32(adl_pkg::OFF_CTRL, 32'h1);
    wr32(adl_pkg::OFF_IDX_BASE, 32'hFF0);
    add_reg(16'h245F, 12'h04F, 8'h80, 8'h80);
    add_reg(16'h2660, 12'h060, 8'h08, 8'h08);
    add_reg(16'h255F, 12'h35F, 8'h10, 8'h20);
    wr32(adl_pkg::OFF_CTRL, 32'h0);
    add_reg(16'h245F, 12'h05F, 8'h44, 8'h44);
    test_done();
  end
endmodule
